// >>> core/imr_pkg.sv
package imr_pkg;
	// register port geometry
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;
	localparam int CTRL_W = 7;
	localparam int STAT_W = 7;
	// register offsets
	localparam logic [ADDR_W-1:0] OFF_CTRL = 3'h0;
	localparam logic [ADDR_W-1:0] OFF_STAT = 3'h1;
	localparam logic [ADDR_W-1:0] OFF_DATA = 3'h2;
	localparam logic [ADDR_W-1:0] OFF_BAUD = 3'h3;
	localparam logic [ADDR_W-1:0] OFF_CFG = 3'h4;
	// field positions and reset values
	localparam int CFG_EN = 0;
	localparam logic [DATA_W-1:0] BAUD_RST = 8'h09;
	localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam logic [2:0] FIRST_BIT = 3'h0;
	localparam int MSB = DATA_W - 1;

	// serial_control_two, bit 0 upward: start .. ack_received_status
	typedef struct packed {
		logic ack_received_status;
		logic ack_value_bit;
		logic ack_sequence_enable;
		logic receive_enable_bit;
		logic stop_enable_bit;
		logic rstart_enable_bit;
		logic start_enable_bit;
	} imr_ctrl_t;

	// serial_status_register, bit 0 upward: buffer_full .. stop_detected
	typedef struct packed {
		logic stop_detected;
		logic start_detected;
		logic serial_interrupt_flag;
		logic bus_collision_flag;
		logic write_collision_flag;
		logic receive_overflow_flag;
		logic buffer_full_flag;
	} imr_stat_t;

	typedef enum logic [4:0] {
		S_IDLE, S_ST_REL, S_ST_LOW,
		S_RS_LOW, S_RS_REL, S_RS_HIGH, S_RS_SDA,
		S_TX_LOW, S_TX_HIGH, S_TA_LOW, S_TA_HIGH,
		S_RX_LOW, S_RX_HIGH, S_AK_LOW, S_AK_HIGH,
		S_SP_LOW, S_SP_CNT, S_SP_SCL, S_SP_REL, S_SP_END
	} imr_state_t;
endpackage

// >>> core/imr_baud.sv
`timescale 1ns/1ns
// reload counter: tick while running and the count sits at zero
module imr_baud #(
	parameter int W = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// control
	input wire logic run,
	input wire logic load,
	input wire logic [W-1:0] reload,
	// rollover
	output logic tick
);
	logic [W-1:0] cnt_r;

	always_ff @(posedge clk) begin
		if (!rst_n || load) begin
			cnt_r <= reload;
		end else if (run) begin
			if (cnt_r == '0) begin
				cnt_r <= reload;
			end else begin
				cnt_r <= cnt_r - 1'b1;
			end
		end
	end

	assign tick = run && (cnt_r == '0);
endmodule

// >>> core/imr_core.sv
// Behaviour
// RULE1: receive enable writes are ignored unless the module is idle.
// RULE2: in reception each baud rollover toggles clock; data shifts in.
// RULE3: after eighth fall: clear enable, load buffer, set flags, hold clock low.
// RULE4: buffer full sets on each byte loaded, clears on buffer read.
// RULE5: overflow sets when a byte completes while buffer full is still set.
// RULE6: buffer write while busy sets write collision, buffer unchanged.
// RULE7: ack enable pulls clock low and puts ack value on data.
// RULE8: ack: one period low, release, one high period, low, go idle.
// RULE9: stop: data low, wait sampled, count, release clock, later data.
// RULE10: data high with clock high sets stop flag; period later interrupt.
// RULE11: reset disables the module and aborts any transfer.
// RULE12: start and stop flags clear on reset and while disabled.
// RULE13: software claims bus only when stop seen or bus idle.
// RULE14: released data sampled low with clock high is a collision.
// RULE15: tx collision halts, clears buffer full, releases both lines.
// RULE16: sequence collision aborts, releases lines, clears its enable.
// RULE17: after collision a bus stop sets the serial interrupt flag.
// RULE18: a new buffer write after collision restarts from the first bit.
// RULE19: start with either line low aborts with bus collision.
// RULE20: start: count with data high; clock low is collision; early data.
// RULE21: repeated start collision: data low at clock rise, clock falling early.
// RULE22: repeated start: data low, count, then clock low regardless.
// RULE23: every timed period reloads from the baud reload register.
// RULE24: software keeps baud reload values above 0x02.
// RULE25: lines are open drain and sampled on the core clock.
`timescale 1ns/1ns
module imr_core (
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RESETN,
	// register port
	input wire logic [imr_pkg::ADDR_W-1:0] REG_ADDR,
	input wire logic [imr_pkg::DATA_W-1:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [imr_pkg::DATA_W-1:0] REG_RDATA,
	// i2c clock line
	input wire logic SCL_I,
	output logic SCL_O,
	output logic SCL_OE,
	// i2c data line
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE
);
	import imr_pkg::*;

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
		return a == off;
	endfunction

	logic [1:0] sync1_r, sync2_r, sync3_r, line_r, line_d_r;
	logic scl_s, sda_s, start_cond, stop_cond;
	logic enable_r, collided_r;
	logic [DATA_W-1:0] baud_r, buf_r, shift_r, shift_nxt;
	logic [2:0] bit_r, bit_nxt;
	imr_ctrl_t ctrl_r, ctl_clr, ctl_w;
	imr_stat_t stat_r, st_w;
	imr_state_t state_r, state_nxt;
	logic scl_drv_r, scl_nxt, sda_drv_r, sda_nxt;
	logic brg_run, brg_load, tick;
	logic wr_ctrl, wr_stat, wr_data, rd_data, idle_ok, tx_go;
	logic coll, set_sif, bf_clr, rx_done, ackrx_we;

	// line sampling, bit 1 clock, bit 0 data
	always_ff @(posedge CORE_CLK) begin
		if (!RESETN) begin
			sync1_r <= 2'h3;
			sync2_r <= 2'h3;
			sync3_r <= 2'h3;
			line_d_r <= 2'h3;
		end else begin
			sync1_r <= {SCL_I, SDA_I}; // [RULE25]
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			line_d_r <= line_r;
		end
	end

	for (genvar g = 0; g < 2; g++) begin : g_line
		always_ff @(posedge CORE_CLK) begin
			if (!RESETN) begin
				line_r[g] <= 1'b1;
			end else if (sync2_r[g] == sync3_r[g]) begin
				line_r[g] <= sync3_r[g];
			end
		end
	end

	assign scl_s = line_r[1];
	assign sda_s = line_r[0];
	assign start_cond = scl_s && line_d_r[1] && line_d_r[0] && !sda_s;
	assign stop_cond = scl_s && line_d_r[1] && !line_d_r[0] && sda_s;

	// register decode
	assign wr_ctrl = REG_WR && hit(REG_ADDR, OFF_CTRL);
	assign wr_stat = REG_WR && hit(REG_ADDR, OFF_STAT);
	assign wr_data = REG_WR && hit(REG_ADDR, OFF_DATA);
	assign rd_data = REG_RD && hit(REG_ADDR, OFF_DATA);
	assign ctl_w = imr_ctrl_t'(REG_WDATA[CTRL_W-1:0]);
	assign st_w = imr_stat_t'(REG_WDATA[STAT_W-1:0]);
	assign idle_ok = (state_r == S_IDLE) && !(ctrl_r.start_enable_bit || ctrl_r.rstart_enable_bit
		|| ctrl_r.stop_enable_bit || ctrl_r.receive_enable_bit || ctrl_r.ack_sequence_enable);
	assign tx_go = wr_data && idle_ok && enable_r;

	imr_baud #(
		.W(DATA_W)
	) u_brg (
		.clk(CORE_CLK),
		.rst_n(RESETN),
		.run(brg_run),
		.load(brg_load),
		.reload(baud_r), // [RULE23]
		.tick(tick)
	);

	// sequencer; drive bits are 1 while pulling a line low
	always_comb begin
		state_nxt = state_r;
		scl_nxt = scl_drv_r;
		sda_nxt = sda_drv_r;
		shift_nxt = shift_r;
		bit_nxt = bit_r;
		brg_run = 1'b0;
		ctl_clr = '0;
		coll = 1'b0;
		set_sif = 1'b0;
		bf_clr = 1'b0;
		rx_done = 1'b0;
		ackrx_we = 1'b0;
		case (state_r)
			S_IDLE: begin
				if (ctrl_r.start_enable_bit) begin
					if (!scl_s || !sda_s) begin
						coll = 1'b1; // [RULE19]
					end else begin
						state_nxt = S_ST_REL;
						scl_nxt = 1'b0;
						sda_nxt = 1'b0;
					end
				end else if (ctrl_r.rstart_enable_bit) begin
					state_nxt = S_RS_LOW;
					scl_nxt = 1'b1;
					sda_nxt = 1'b0;
				end else if (ctrl_r.stop_enable_bit) begin
					state_nxt = S_SP_LOW;
					scl_nxt = 1'b1;
					sda_nxt = 1'b1; // [RULE9]
				end else if (ctrl_r.receive_enable_bit) begin
					state_nxt = S_RX_LOW;
					scl_nxt = 1'b1;
					sda_nxt = 1'b0;
					bit_nxt = FIRST_BIT;
				end else if (ctrl_r.ack_sequence_enable) begin
					state_nxt = S_AK_LOW;
					scl_nxt = 1'b1;
					sda_nxt = !ctrl_r.ack_value_bit; // [RULE7]
				end else if (tx_go) begin
					state_nxt = S_TX_LOW;
					scl_nxt = 1'b1;
					shift_nxt = REG_WDATA;
					sda_nxt = !REG_WDATA[MSB];
					bit_nxt = FIRST_BIT; // [RULE18]
				end
			end
			S_ST_REL: begin
				brg_run = 1'b1;
				if (!scl_s && sda_s) begin
					coll = 1'b1; // [RULE20]
				end else if (!sda_s || tick) begin
					state_nxt = S_ST_LOW; // [RULE20]
					sda_nxt = 1'b1;
				end
			end
			S_ST_LOW: begin
				brg_run = 1'b1;
				if (tick) begin
					state_nxt = S_IDLE;
					scl_nxt = 1'b1;
					ctl_clr.start_enable_bit = 1'b1;
					set_sif = 1'b1;
				end
			end
			S_RS_LOW: begin
				brg_run = 1'b1;
				if (tick) begin
					state_nxt = S_RS_REL;
					scl_nxt = 1'b0;
				end
			end
			S_RS_REL: begin
				if (scl_s) begin
					if (!sda_s) begin
						coll = 1'b1; // [RULE21]
					end else begin
						state_nxt = S_RS_HIGH;
					end
				end
			end
			S_RS_HIGH: begin
				brg_run = 1'b1;
				if (!scl_s && sda_s) begin
					coll = 1'b1; // [RULE21]
				end else if (tick) begin
					state_nxt = S_RS_SDA; // [RULE22]
					sda_nxt = 1'b1;
				end
			end
			S_RS_SDA: begin
				brg_run = 1'b1;
				if (tick) begin
					state_nxt = S_IDLE;
					scl_nxt = 1'b1; // [RULE22]
					ctl_clr.rstart_enable_bit = 1'b1;
					set_sif = 1'b1;
				end
			end
			S_TX_LOW, S_TA_LOW, S_RX_LOW, S_AK_LOW: begin
				brg_run = 1'b1;
				if (tick) begin
					scl_nxt = 1'b0; // [RULE2] [RULE8]
					case (state_r)
						S_TX_LOW: state_nxt = S_TX_HIGH;
						S_TA_LOW: state_nxt = S_TA_HIGH;
						S_RX_LOW: state_nxt = S_RX_HIGH;
						default: state_nxt = S_AK_HIGH;
					endcase
				end
			end
			S_TX_HIGH: begin
				brg_run = scl_s;
				if (scl_s && !sda_drv_r && !sda_s) begin
					coll = 1'b1; // [RULE14]
					bf_clr = 1'b1; // [RULE15]
				end else if (tick) begin
					scl_nxt = 1'b1;
					if (bit_r == LAST_BIT) begin
						state_nxt = S_TA_LOW;
						sda_nxt = 1'b0;
						bf_clr = 1'b1;
					end else begin
						state_nxt = S_TX_LOW;
						bit_nxt = bit_r + 1'b1;
						shift_nxt = {shift_r[MSB-1:0], 1'b0};
						sda_nxt = !shift_r[MSB-1];
					end
				end
			end
			S_TA_HIGH: begin
				brg_run = scl_s;
				if (tick) begin
					state_nxt = S_IDLE;
					scl_nxt = 1'b1;
					ackrx_we = 1'b1;
					set_sif = 1'b1;
				end
			end
			S_RX_HIGH: begin
				brg_run = scl_s;
				if (tick) begin
					scl_nxt = 1'b1; // [RULE2]
					shift_nxt = {shift_r[MSB-1:0], sda_s}; // [RULE2]
					if (bit_r == LAST_BIT) begin
						state_nxt = S_IDLE; // [RULE3]
						ctl_clr.receive_enable_bit = 1'b1;
						rx_done = 1'b1;
						set_sif = 1'b1;
					end else begin
						state_nxt = S_RX_LOW;
						bit_nxt = bit_r + 1'b1;
					end
				end
			end
			S_AK_HIGH: begin
				brg_run = scl_s;
				if (scl_s && !sda_drv_r && !sda_s) begin
					coll = 1'b1; // [RULE16]
				end else if (tick) begin
					state_nxt = S_IDLE; // [RULE8]
					scl_nxt = 1'b1;
					ctl_clr.ack_sequence_enable = 1'b1;
					set_sif = 1'b1;
				end
			end
			S_SP_LOW: begin
				if (!sda_s) begin
					state_nxt = S_SP_CNT;
				end
			end
			S_SP_CNT: begin
				brg_run = 1'b1;
				if (tick) begin
					state_nxt = S_SP_SCL; // [RULE9]
					scl_nxt = 1'b0;
				end
			end
			S_SP_SCL: begin
				brg_run = scl_s;
				if (tick) begin
					state_nxt = S_SP_REL; // [RULE9]
					sda_nxt = 1'b0;
				end
			end
			S_SP_REL: begin
				if (sda_s && scl_s) begin
					state_nxt = S_SP_END;
				end
			end
			S_SP_END: begin
				brg_run = 1'b1;
				if (tick) begin
					state_nxt = S_IDLE; // [RULE10]
					ctl_clr.stop_enable_bit = 1'b1;
					set_sif = 1'b1;
				end
			end
			default: begin
				state_nxt = S_IDLE;
			end
		endcase
		if (coll) begin
			state_nxt = S_IDLE; // [RULE16]
			scl_nxt = 1'b0;
			sda_nxt = 1'b0;
			ctl_clr.start_enable_bit = 1'b1;
			ctl_clr.rstart_enable_bit = 1'b1;
			ctl_clr.stop_enable_bit = 1'b1;
			ctl_clr.receive_enable_bit = 1'b1;
			ctl_clr.ack_sequence_enable = 1'b1;
		end
	end

	assign brg_load = state_nxt != state_r; // [RULE23]

	// sequencer state; reset or disable aborts everything
	always_ff @(posedge CORE_CLK) begin
		if (!RESETN || !enable_r) begin
			state_r <= S_IDLE; // [RULE11]
			scl_drv_r <= 1'b0;
			sda_drv_r <= 1'b0;
			shift_r <= DATA_RST;
			bit_r <= FIRST_BIT;
		end else begin
			state_r <= state_nxt;
			scl_drv_r <= scl_nxt;
			sda_drv_r <= sda_nxt;
			shift_r <= shift_nxt;
			bit_r <= bit_nxt;
		end
	end

	// configuration and baud reload
	always_ff @(posedge CORE_CLK) begin
		if (!RESETN) begin
			enable_r <= 1'b0; // [RULE11]
			baud_r <= BAUD_RST;
		end else begin
			if (REG_WR && hit(REG_ADDR, OFF_CFG)) begin
				enable_r <= REG_WDATA[CFG_EN];
			end
			if (REG_WR && hit(REG_ADDR, OFF_BAUD)) begin
				baud_r <= REG_WDATA;
			end
		end
	end

	// control bits: enables accepted only while idle
	always_ff @(posedge CORE_CLK) begin
		if (!RESETN) begin
			ctrl_r <= '0;
		end else if (!enable_r) begin
			ctrl_r.start_enable_bit <= 1'b0;
			ctrl_r.rstart_enable_bit <= 1'b0;
			ctrl_r.stop_enable_bit <= 1'b0;
			ctrl_r.receive_enable_bit <= 1'b0;
			ctrl_r.ack_sequence_enable <= 1'b0;
			if (wr_ctrl) begin
				ctrl_r.ack_value_bit <= ctl_w.ack_value_bit;
			end
		end else begin
			ctrl_r.start_enable_bit <= (wr_ctrl && idle_ok && ctl_w.start_enable_bit)
				|| (ctrl_r.start_enable_bit && !ctl_clr.start_enable_bit);
			ctrl_r.rstart_enable_bit <= (wr_ctrl && idle_ok && ctl_w.rstart_enable_bit)
				|| (ctrl_r.rstart_enable_bit && !ctl_clr.rstart_enable_bit);
			ctrl_r.stop_enable_bit <= (wr_ctrl && idle_ok && ctl_w.stop_enable_bit)
				|| (ctrl_r.stop_enable_bit && !ctl_clr.stop_enable_bit);
			ctrl_r.receive_enable_bit <= (wr_ctrl && idle_ok && ctl_w.receive_enable_bit) // [RULE1]
				|| (ctrl_r.receive_enable_bit && !ctl_clr.receive_enable_bit);
			ctrl_r.ack_sequence_enable <= (wr_ctrl && idle_ok && ctl_w.ack_sequence_enable)
				|| (ctrl_r.ack_sequence_enable && !ctl_clr.ack_sequence_enable);
			if (wr_ctrl) begin
				ctrl_r.ack_value_bit <= ctl_w.ack_value_bit; // [RULE7]
			end
			if (ackrx_we) begin
				ctrl_r.ack_received_status <= sda_s;
			end
		end
	end

	// data buffer
	always_ff @(posedge CORE_CLK) begin
		if (!RESETN) begin
			buf_r <= DATA_RST;
		end else if (rx_done) begin
			buf_r <= shift_nxt; // [RULE3]
		end else if (tx_go) begin
			buf_r <= REG_WDATA; // [RULE6]
		end
	end

	// status flags; hardware set wins over software clear
	always_ff @(posedge CORE_CLK) begin
		if (!RESETN) begin
			stat_r <= '0;
			collided_r <= 1'b0;
		end else begin
			stat_r.buffer_full_flag <= rx_done || tx_go // [RULE4]
				|| (stat_r.buffer_full_flag && !rd_data && !bf_clr);
			stat_r.receive_overflow_flag <= (rx_done && stat_r.buffer_full_flag) // [RULE5]
				|| (stat_r.receive_overflow_flag && !(wr_stat && st_w.receive_overflow_flag));
			stat_r.write_collision_flag <= (wr_data && !idle_ok) // [RULE6]
				|| (stat_r.write_collision_flag && !(wr_stat && st_w.write_collision_flag));
			stat_r.bus_collision_flag <= coll // [RULE14]
				|| (stat_r.bus_collision_flag && !(wr_stat && st_w.bus_collision_flag));
			stat_r.serial_interrupt_flag <= set_sif || (collided_r && stop_cond) // [RULE17]
				|| (stat_r.serial_interrupt_flag && !(wr_stat && st_w.serial_interrupt_flag));
			collided_r <= coll || (collided_r && !stop_cond && enable_r);
			if (!enable_r) begin
				stat_r.start_detected <= 1'b0; // [RULE12]
				stat_r.stop_detected <= 1'b0;
			end else if (start_cond) begin
				stat_r.start_detected <= 1'b1;
				stat_r.stop_detected <= 1'b0;
			end else if (stop_cond) begin
				stat_r.start_detected <= 1'b0;
				stat_r.stop_detected <= 1'b1; // [RULE10]
			end
		end
	end

	// read data stands only in the cycle after each REG_RD cycle
	always_ff @(posedge CORE_CLK) begin
		if (!RESETN || !REG_RD) begin
			REG_RDATA <= DATA_RST;
		end else begin
			case (REG_ADDR)
				OFF_CTRL: REG_RDATA <= DATA_W'(ctrl_r);
				OFF_STAT: REG_RDATA <= DATA_W'(stat_r);
				OFF_DATA: REG_RDATA <= buf_r;
				OFF_BAUD: REG_RDATA <= baud_r;
				OFF_CFG: REG_RDATA <= DATA_W'(enable_r);
				default: REG_RDATA <= DATA_RST;
			endcase
		end
	end

	// open drain: only ever pull low
	assign SCL_O = 1'b0;
	assign SDA_O = 1'b0;
	assign SCL_OE = scl_drv_r; // [RULE25]
	assign SDA_OE = sda_drv_r; // [RULE25]
endmodule

// >>> sim/imr_chk_sva.sv
`timescale 1ns/1ns
module imr_chk
	import imr_pkg::*;
(
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RESETN,
	// register port
	input wire logic [imr_pkg::ADDR_W-1:0] REG_ADDR,
	input wire logic [imr_pkg::DATA_W-1:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [imr_pkg::DATA_W-1:0] REG_RDATA,
	// bus lines
	input wire logic SCL_I,
	input wire logic SCL_O,
	input wire logic SCL_OE,
	input wire logic SDA_I,
	input wire logic SDA_O,
	input wire logic SDA_OE
);
	logic en_r;
	logic [7:0] baud_r;
	// shadow of the enable and reload registers
	always_ff @(posedge CORE_CLK) begin
		if (!RESETN) begin
			en_r <= 1'b0;
			baud_r <= BAUD_RST;
		end else if (REG_WR && REG_ADDR == OFF_CFG) begin
			en_r <= REG_WDATA[CFG_EN];
		end else if (REG_WR && REG_ADDR == OFF_BAUD) begin
			baud_r <= REG_WDATA;
		end
	end
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!RESETN);
	// far side holds the released clock low
	sequence scl_held_s;
		(!SCL_OE && !SCL_I && !SDA_OE) [*6];
	endsequence
	sequence first_rd_s;
		RESETN && !$past(RESETN) && REG_RD && REG_ADDR == OFF_STAT;
	endsequence
	lines_od_a: assert property (SCL_O == 1'b0 && SDA_O == 1'b0)
		else $error("line drive level not low");
	reset_rel_a: assert property (@(posedge CORE_CLK) disable iff (1'b0)
		!RESETN |=> !SCL_OE && !SDA_OE && REG_RDATA == 8'h00) else $error("reset left a line driven");
	status_clr_a: assert property (first_rd_s |=> REG_RDATA == 8'h00)
		else $error("status not clear after reset");
	rdata_idle_a: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
		else $error("read data outside read slot");
	sda_edge_a: assert property ($changed(SDA_OE) && !SCL_OE |-> $past(SCL_I, 6))
		else $error("data moved under a low released clock");
	stretch_hold_a: assert property (scl_held_s |=> !SCL_OE)
		else $error("clock driven during stretch");
	low_min_a: assert property ($rose(SCL_OE) |=> SCL_OE [*2])
		else $error("clock low phase too short");
	disabled_a: assert property (!en_r && !$past(en_r) |-> !SCL_OE && !SDA_OE)
		else $error("disabled module drives a line");
	baud_rd_a: assert property (REG_RD && REG_ADDR == OFF_BAUD |=> REG_RDATA == baud_r)
		else $error("reload register read mismatch");
endmodule
bind imr_core imr_chk chk_u (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
	.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .SCL_I(SCL_I), .SCL_O(SCL_O), .SCL_OE(SCL_OE),
	.SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE(SDA_OE));

// >>> sim/imr_peer.sv
`timescale 1ns/1ns
// slave: shifts a byte out msb first, may stretch clock lows
module imr_peer (
	// clock
	input wire logic clk,
	// bus levels
	input wire logic scl,
	input wire logic sda,
	// control
	input wire logic send,
	input wire logic [7:0] tx_byte,
	input wire logic [4:0] stretch,
	// drives and the data level sampled at the last clock rise
	output logic sda_pull,
	output logic scl_pull,
	output logic rise_sda
);
	logic scl_d, send_d;
	logic [3:0] cnt;
	logic [4:0] hold;
	logic [7:0] sh;
	initial begin
		scl_d = 1'b1;
		send_d = 1'b0;
		cnt = 4'h0;
		hold = 5'h00;
		sh = 8'h00;
		sda_pull = 1'b0;
		rise_sda = 1'b1;
	end
	assign scl_pull = hold != 5'h00;
	always @(posedge clk) begin
		scl_d <= scl;
		send_d <= send;
		if (send && !send_d) begin
			cnt <= 4'h0;
			sh <= tx_byte << 1;
			sda_pull <= !tx_byte[7];
		end else if (scl && !scl_d) begin
			cnt <= cnt + 4'h1;
			rise_sda <= sda;
		end else if (!scl && scl_d && cnt != 4'h0) begin
			sh <= sh << 1;
			// released after the eighth bit so the master owns the ack slot
			sda_pull <= send && cnt < 4'h8 && !sh[7];
		end
	end
	always @(posedge clk) begin
		if (!scl && scl_d && send) begin
			hold <= stretch;
		end else if (hold != 5'h00) begin
			hold <= hold - 5'h01;
		end
	end
endmodule

// >>> sim/testbench.sv
`timescale 1ns/1ns
module testbench;
	import imr_pkg::*;
	logic clk, rstn, wr_s, rd_s, scl_oe, sda_oe, p_scl, p_sda, tb_sda, scl, sda, send, ack_seen;
	logic [ADDR_W-1:0] addr;
	logic [7:0] wdata, rdata, d, tx_byte;
	logic [4:0] stretch;
	int bad_count;
	int total_checks;
	// wired-and with pull-ups
	assign scl = !(scl_oe | p_scl);
	assign sda = !(sda_oe | p_sda | tb_sda);
	initial begin
		clk = 1'b0;
		forever #4 clk = !clk;
	end
	imr_core dut_u (.CORE_CLK(clk), .RESETN(rstn), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr_s),
		.REG_RD(rd_s), .REG_RDATA(rdata), .SCL_I(scl), .SCL_O(), .SCL_OE(scl_oe), .SDA_I(sda), .SDA_O(),
		.SDA_OE(sda_oe));
	imr_peer peer_u (.clk(clk), .scl(scl), .sda(sda), .send(send), .tx_byte(tx_byte), .stretch(stretch),
		.sda_pull(p_sda), .scl_pull(p_scl), .rise_sda(ack_seen));
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] v);
		@(posedge clk);
		wr_s <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a);
		@(posedge clk);
		rd_s <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic rchk(input logic [ADDR_W-1:0] a, input logic [7:0] m, input logic [7:0] e);
		rd(a);
		chk(d & m, e);
	endtask
	task automatic wait_stat(input int b);
		for (int i = 0; i < 400; i++) begin
			rd(OFF_STAT);
			if (d[b] === 1'b1) return;
		end
		bad_count++;
		$display("CHECK FAILED at %0t: status wait timed out", $time);
		give_verdict();
	endtask
	task automatic rx(input logic [7:0] b, input logic [4:0] s);
		@(posedge clk);
		tx_byte <= b;
		stretch <= s;
		send <= 1'b1;
		wr(OFF_CTRL, 8'h08);
	endtask
	task automatic rx_end();
		wait_stat(4);
		@(posedge clk);
		send <= 1'b0;
		wr(OFF_STAT, 8'h10);
	endtask
	task automatic sc_refuse();
		wr(OFF_CTRL, 8'h08);
		rchk(OFF_CTRL, 8'h1f, 8'h00);
		chk({6'h00, scl_oe, sda_oe}, 8'h00);
		wr(OFF_CFG, 8'h01);
		rchk(OFF_BAUD, 8'hff, BAUD_RST);
		wr(OFF_BAUD, 8'h07);
		rchk(OFF_BAUD, 8'hff, 8'h07);
	endtask
	task automatic sc_receive();
		rx(8'ha5, 5'h00);
		wr(OFF_DATA, 8'h55);
		wr(OFF_CTRL, 8'h18);
		rx_end();
		rchk(OFF_CTRL, 8'h1f, 8'h00);
		chk({7'h00, scl_oe}, 8'h01);
		rchk(OFF_STAT, 8'h07, 8'h05);
		rchk(OFF_DATA, 8'hff, 8'ha5);
		rchk(OFF_STAT, 8'h01, 8'h00);
		wr(OFF_STAT, 8'h1e);
	endtask
	task automatic sc_overflow();
		rx(8'h3c, 5'h14);
		rx_end();
		rx(8'hc3, 5'h00);
		rx_end();
		rchk(OFF_STAT, 8'h03, 8'h03);
		rd(OFF_DATA);
		wr(OFF_STAT, 8'h1e);
	endtask
	task automatic sc_ack();
		for (int v = 0; v < 2; v++) begin
			wr(OFF_CTRL, v ? 8'h30 : 8'h10);
			wait_stat(4);
			chk({7'h00, ack_seen}, 8'(v));
			chk({7'h00, scl_oe}, 8'h01);
			rchk(OFF_CTRL, 8'h10, 8'h00);
			wr(OFF_STAT, 8'h10);
		end
	endtask
	task automatic sc_stop();
		wr(OFF_CTRL, 8'h04);
		wait_stat(4);
		rchk(OFF_STAT, 8'h40, 8'h40);
		rchk(OFF_CTRL, 8'h04, 8'h00);
		chk({6'h00, scl_oe, sda_oe}, 8'h00);
		wr(OFF_STAT, 8'h10);
	endtask
	task automatic sc_collide();
		@(posedge clk);
		tb_sda <= 1'b1;
		wait_stat(5);
		wr(OFF_CTRL, 8'h01);
		wait_stat(3);
		rchk(OFF_CTRL, 8'h01, 8'h00);
		chk({6'h00, scl_oe, sda_oe}, 8'h00);
		@(posedge clk);
		tb_sda <= 1'b0;
		wait_stat(4);
		wr(OFF_STAT, 8'h1e);
		wr(OFF_DATA, 8'hff);
		@(posedge clk);
		tb_sda <= 1'b1;
		wait_stat(3);
		rchk(OFF_STAT, 8'h09, 8'h08);
		chk({6'h00, scl_oe, sda_oe}, 8'h00);
		@(posedge clk);
		tb_sda <= 1'b0;
		wait_stat(4);
		rchk(OFF_STAT, 8'h40, 8'h40);
		wr(OFF_STAT, 8'h1e);
	endtask
	task automatic sc_start();
		wr(OFF_CTRL, 8'h01);
		wait_stat(4);
		chk({6'h00, scl_oe, sda_oe}, 8'h03);
		rchk(OFF_CTRL, 8'h01, 8'h00);
		wr(OFF_STAT, 8'h10);
		wr(OFF_CTRL, 8'h02);
		wait_stat(4);
		chk({6'h00, scl_oe, sda_oe}, 8'h03);
		rchk(OFF_CTRL, 8'h02, 8'h00);
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		#1 chk({6'h00, scl_oe, sda_oe}, 8'h00);
	endtask
	initial begin
		rstn = 1'b0;
		wr_s = 1'b0;
		rd_s = 1'b0;
		addr = OFF_CTRL;
		wdata = 8'h00;
		tb_sda = 1'b0;
		send = 1'b0;
		tx_byte = 8'h00;
		stretch = 5'h00;
		bad_count = 0;
		total_checks = 0;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		rd_s <= 1'b1;
		addr <= OFF_STAT;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 chk(rdata, 8'h00);
		sc_refuse();
		sc_receive();
		sc_overflow();
		sc_ack();
		sc_stop();
		sc_collide();
		sc_start();
		give_verdict();
	end
endmodule
